// ---- design/dtc_top.sv ----
`timescale 1ns/1ps
`include "dtc_params.svh"
// How it works
// [RL1] Bursts of one, two, four or eight bytes
// [RL2] Block size from one byte to 64KB
// [RL3] Repeat counter re-runs block, up to 16MB
// [RL4] Addresses fixed, incrementing or decrementing per byte
// [RL5] Address reload after burst, block or transaction
// [RL6] Start on software, peripheral or event trigger
// [RL7] Each channel keeps its own settings
// [RL8] Interrupt on transaction done or error
// [RL9] Chaining hands transfer to the other channel
// [RL10] Memory and peripheral transfers in any combination
// [RL11] Memory-mapped nonvolatile region usable as source
// [RL12] Moved bytes optionally forwarded to CRC
// [RL13] Nonvolatile reads issued every second cycle
// [RL14] Separate read and write bus masters
// [RL15] Fixed or alternating channel priority
module dtc_top (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	// AXI4-Lite slave
	input  wire logic                 i_awvalid,
	output logic                      o_awready,
	input  wire logic [7:0]           i_awaddr,
	input  wire logic                 i_wvalid,
	output logic                      o_wready,
	input  wire logic [31:0]          i_wdata,
	input  wire logic [3:0]           i_wstrb,
	output logic                      o_bvalid,
	input  wire logic                 i_bready,
	output logic [1:0]                o_bresp,
	input  wire logic                 i_arvalid,
	output logic                      o_arready,
	input  wire logic [7:0]           i_araddr,
	output logic                      o_rvalid,
	input  wire logic                 i_rready,
	output logic [31:0]               o_rdata,
	output logic [1:0]                o_rresp,
	// Triggers
	input  wire logic [1:0]           i_periph_req,
	input  wire logic [1:0]           i_event,
	// Read and write masters
	output dtc_pkg::dtc_rd_req_t      o_rd,
	input  wire dtc_pkg::dtc_rd_rsp_t i_rd,
	output dtc_pkg::dtc_wr_req_t      o_wr,
	input  wire dtc_pkg::dtc_wr_rsp_t i_wr,
	// CRC feed and interrupt
	output dtc_pkg::dtc_crc_t         o_crc,
	output logic                      o_irq
);
	import dtc_pkg::*;

	dtc_state_t s_reg, s_next;
	dtc_chan_t  c;
	logic       rd_iss, wr_acc, bend, aerr;
	logic [1:0] done_ev, err_ev, swt, cand;
	logic [3:0] clr;
	logic [31:0] tmp;

	function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] st);
		logic [31:0] m;
		m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
		return (o & ~m) | (d & m);
	endfunction

	function automatic logic [23:0] step(input logic [23:0] a, input logic [1:0] mode);
		return (mode == `DTC_AM_INC) ? a + 24'h1 : (mode == `DTC_AM_DEC) ? a - 24'h1 : a;
	endfunction

	function automatic logic is_nvm(input logic [23:0] a);
		return (a & `DTC_NVM_MASK) == `DTC_NVM_BASE;
	endfunction

	// Returns hit and channel index of a channel page address
	function automatic logic [1:0] chan_of(input logic [7:0] a);
		return {(a[7:5] == `DTC_PG_CH0) || (a[7:5] == `DTC_PG_CH1), a[7:5] == `DTC_PG_CH1};
	endfunction

	function automatic dtc_chan_t start_ch(input dtc_chan_t x);
		dtc_chan_t y;
		y = x;
		y.busy = 1'b1;
		y.src_cur = x.src;
		y.dst_cur = x.dst;
		y.blk_left = (x.blk == 16'h0) ? `DTC_BLK_FULL : {1'b0, x.blk};
		y.rep_left = (x.rep == 8'h0) ? `DTC_REP_FULL : {1'b0, x.rep};
		return y;
	endfunction

	assign o_awready = !s_reg.aw_got && !s_reg.bvalid;
	assign o_wready  = !s_reg.w_got && !s_reg.bvalid;
	assign o_arready = !s_reg.rvalid;
	assign o_bvalid  = s_reg.bvalid;
	assign o_bresp   = s_reg.bresp;
	assign o_rvalid  = s_reg.rvalid;
	assign o_rdata   = s_reg.rdata;
	assign o_rresp   = s_reg.rresp;
	assign o_rd      = s_reg.rd;
	assign o_wr      = s_reg.wr;
	assign o_crc     = s_reg.crc;
	assign o_irq     = |(s_reg.istat & s_reg.imask);

	always_comb
	begin
		s_next = s_reg;
		c = s_reg.ch[s_reg.act];
		rd_iss = 1'b0;
		wr_acc = 1'b0;
		bend = 1'b0;
		aerr = 1'b0;
		done_ev = 2'b00;
		err_ev = 2'b00;
		swt = 2'b00;
		cand = 2'b00;
		clr = 4'h0;
		tmp = 32'h0;
		s_next.crc.valid = 1'b0;
		// Write channels taken in either order, acted on once both are held
		if (i_awvalid && o_awready)
		begin
			s_next.aw_got = 1'b1;
			s_next.awaddr = i_awaddr;
		end
		if (i_wvalid && o_wready)
		begin
			s_next.w_got = 1'b1;
			s_next.wdata = i_wdata;
			s_next.wstrb = i_wstrb;
		end
		if (s_reg.bvalid && i_bready)
			s_next.bvalid = 1'b0;
		if (s_reg.aw_got && s_reg.w_got)
		begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = `DTC_RESP_OK;
			if (chan_of(s_reg.awaddr) == 2'b00 || chan_of(s_reg.awaddr) == 2'b01)
			begin
				case (s_reg.awaddr)
					`DTC_A_PRIO: begin
						tmp = merge({31'h0, s_reg.prio}, s_reg.wdata, s_reg.wstrb);
						s_next.prio = tmp[`DTC_PRIO_RR];
					end
					`DTC_A_ISTAT: begin
						tmp = merge(32'h0, s_reg.wdata, s_reg.wstrb);
						clr = tmp[3:0];
					end
					`DTC_A_IMASK: begin
						tmp = merge({28'h0, s_reg.imask}, s_reg.wdata, s_reg.wstrb);
						s_next.imask = tmp[3:0];
					end
					`DTC_A_STATUS: ;
					default: s_next.bresp = `DTC_RESP_ERR;
				endcase
			end
			else
			begin
				// Per-channel settings, fully separate copies
				case (s_reg.awaddr[4:0])
					`DTC_O_CTRL: begin // RL7
						tmp = merge({16'h0, s_reg.ch[s_reg.awaddr[6]].ctrl}, s_reg.wdata,
							s_reg.wstrb);
						swt[s_reg.awaddr[6]] = tmp[`DTC_F_SWTRIG];
						tmp[`DTC_F_SWTRIG] = 1'b0;
						s_next.ch[s_reg.awaddr[6]].ctrl = tmp[15:0];
					end
					`DTC_O_SRC: begin
						tmp = merge({8'h0, s_reg.ch[s_reg.awaddr[6]].src}, s_reg.wdata,
							s_reg.wstrb);
						s_next.ch[s_reg.awaddr[6]].src = tmp[23:0];
					end
					`DTC_O_DST: begin
						tmp = merge({8'h0, s_reg.ch[s_reg.awaddr[6]].dst}, s_reg.wdata,
							s_reg.wstrb);
						s_next.ch[s_reg.awaddr[6]].dst = tmp[23:0];
					end
					`DTC_O_BLK: begin
						tmp = merge({16'h0, s_reg.ch[s_reg.awaddr[6]].blk}, s_reg.wdata,
							s_reg.wstrb);
						s_next.ch[s_reg.awaddr[6]].blk = tmp[15:0];
					end
					`DTC_O_REP: begin
						tmp = merge({24'h0, s_reg.ch[s_reg.awaddr[6]].rep}, s_reg.wdata,
							s_reg.wstrb);
						s_next.ch[s_reg.awaddr[6]].rep = tmp[7:0];
					end
					default: s_next.bresp = `DTC_RESP_ERR;
				endcase
			end
		end
		// Trigger selection per channel
		for (int i = 0; i < 2; i++)
		begin
			if (s_next.ch[i].ctrl[`DTC_F_EN] && !s_reg.ch[i].busy &&
				((s_next.ch[i].ctrl[`DTC_F_TRIG] == `DTC_TRIG_SW && swt[i]) ||
				(s_next.ch[i].ctrl[`DTC_F_TRIG] == `DTC_TRIG_PER && i_periph_req[i]) ||
				(s_next.ch[i].ctrl[`DTC_F_TRIG] == `DTC_TRIG_EVT && i_event[i])))
				s_next.ch[i] = start_ch(s_next.ch[i]); // RL6
			cand[i] = s_reg.ch[i].busy && s_reg.ch[i].ctrl[`DTC_F_EN];
		end
		c = s_next.ch[s_reg.act]; // RL7
		// Engine: one burst per grant, read side then write side
		case (s_reg.st)
			DTC_IDLE: begin
				if (cand != 2'b00)
				begin
					// RL15
					s_next.act = (cand == 2'b11) ? (s_reg.prio && !s_reg.last) : cand[1];
					s_next.last = s_next.act;
					s_next.st = DTC_RD;
					s_next.blen = 4'h1 << s_reg.ch[s_next.act].ctrl[`DTC_F_BURST]; // RL1
					if (s_reg.ch[s_next.act].blk_left < {13'h0, s_next.blen})
						s_next.blen = s_reg.ch[s_next.act].blk_left[3:0];
					s_next.icnt = 4'h0;
					s_next.rcnt = 4'h0;
					s_next.wcnt = 4'h0;
					s_next.nvm_ph = 1'b0;
				end
			end
			DTC_RD: begin
				if (s_reg.rd.valid && i_rd.ready)
					s_next.rd.valid = 1'b0;
				s_next.nvm_ph = 1'b0;
				// Any address, memory or peripheral, is a valid source
				if ((!s_reg.rd.valid || i_rd.ready) && s_reg.icnt != s_reg.blen &&
					!s_reg.nvm_ph)
				begin
					rd_iss = 1'b1;
					s_next.rd.valid = 1'b1; // RL10 RL14
					s_next.rd.addr = c.src_cur;
					s_next.nvm_ph = is_nvm(c.src_cur); // RL11 RL13
					c.src_cur = step(c.src_cur, c.ctrl[`DTC_F_SMODE]); // RL4
					s_next.icnt = s_reg.icnt + 4'h1;
				end
				if (i_rd.dvalid)
				begin
					s_next.bbuf[s_reg.rcnt[2:0]] = i_rd.data;
					s_next.rcnt = s_reg.rcnt + 4'h1;
					if (i_rd.err)
						aerr = 1'b1;
					else if (s_reg.rcnt + 4'h1 == s_reg.blen)
					begin
						s_next.st = DTC_WR;
						s_next.icnt = 4'h0;
					end
				end
			end
			DTC_WR: begin
				if (s_reg.wr.valid && i_wr.ready)
				begin
					wr_acc = 1'b1;
					s_next.wr.valid = 1'b0;
					s_next.wcnt = s_reg.wcnt + 4'h1;
					if (c.ctrl[`DTC_F_CRC])
						s_next.crc = '{valid: 1'b1, data: s_reg.wr.data, ch: s_reg.act}; // RL12
					if (i_wr.err)
						aerr = 1'b1;
					else if (s_reg.wcnt + 4'h1 == s_reg.blen)
						bend = 1'b1;
				end
				if (!aerr && !bend && (!s_reg.wr.valid || i_wr.ready) &&
					s_reg.icnt != s_reg.blen)
				begin
					s_next.wr = '{valid: 1'b1, addr: c.dst_cur, data: s_reg.bbuf[s_reg.icnt[2:0]]};
					c.dst_cur = step(c.dst_cur, c.ctrl[`DTC_F_DMODE]); // RL4 RL14
					s_next.icnt = s_reg.icnt + 4'h1;
				end
				if (bend)
				begin
					s_next.st = DTC_IDLE;
					c.blk_left = c.blk_left - {13'h0, s_reg.blen}; // RL2
					if (c.ctrl[`DTC_F_SRL] == `DTC_RL_BURST)
						c.src_cur = c.src; // RL5
					if (c.ctrl[`DTC_F_DRL] == `DTC_RL_BURST)
						c.dst_cur = c.dst;
					if (c.blk_left == 17'h0)
					begin
						c.rep_left = c.rep_left - 9'h1; // RL3
						c.blk_left = (c.blk == 16'h0) ? `DTC_BLK_FULL : {1'b0, c.blk};
						if (c.ctrl[`DTC_F_SRL] == `DTC_RL_BLOCK)
							c.src_cur = c.src; // RL5
						if (c.ctrl[`DTC_F_DRL] == `DTC_RL_BLOCK)
							c.dst_cur = c.dst;
						if (c.rep_left == 9'h0)
						begin
							c.busy = 1'b0;
							done_ev[s_reg.act] = 1'b1; // RL8
							if (c.ctrl[`DTC_F_SRL] == `DTC_RL_TXN)
								c.src_cur = c.src; // RL5
							if (c.ctrl[`DTC_F_DRL] == `DTC_RL_TXN)
								c.dst_cur = c.dst;
						end
					end
				end
			end
			default: s_next.st = DTC_IDLE;
		endcase
		if (aerr)
		begin
			c.busy = 1'b0;
			err_ev[s_reg.act] = 1'b1; // RL8
			s_next.st = DTC_IDLE;
			s_next.rd.valid = 1'b0;
			s_next.wr.valid = 1'b0;
		end
		if (s_reg.st != DTC_IDLE)
			s_next.ch[s_reg.act] = c;
		if (done_ev[s_reg.act] && c.ctrl[`DTC_F_CHAIN] &&
			s_reg.ch[~s_reg.act].ctrl[`DTC_F_EN] && !s_next.ch[~s_reg.act].busy)
			s_next.ch[~s_reg.act] = start_ch(s_next.ch[~s_reg.act]); // RL9
		// Set wins over a same-cycle write-one-to-clear
		s_next.istat = (s_reg.istat & ~clr) | {err_ev, done_ev};
		// Read channel
		if (i_arvalid && o_arready)
		begin
			s_next.rvalid = 1'b1;
			s_next.rresp = `DTC_RESP_OK;
			s_next.rdata = 32'h0;
			if (chan_of(i_araddr) == 2'b00 || chan_of(i_araddr) == 2'b01)
			begin
				case (i_araddr)
					`DTC_A_PRIO: s_next.rdata = {31'h0, s_reg.prio};
					`DTC_A_ISTAT: s_next.rdata = {28'h0, s_reg.istat};
					`DTC_A_IMASK: s_next.rdata = {28'h0, s_reg.imask};
					`DTC_A_STATUS: s_next.rdata = {27'h0, s_reg.st, s_reg.ch[1].busy,
						s_reg.ch[0].busy};
					default: s_next.rresp = `DTC_RESP_ERR;
				endcase
			end
			else
			begin
				case (i_araddr[4:0])
					`DTC_O_CTRL: s_next.rdata = {16'h0, s_reg.ch[i_araddr[6]].ctrl};
					`DTC_O_SRC: s_next.rdata = {8'h0, s_reg.ch[i_araddr[6]].src};
					`DTC_O_DST: s_next.rdata = {8'h0, s_reg.ch[i_araddr[6]].dst};
					`DTC_O_BLK: s_next.rdata = {16'h0, s_reg.ch[i_araddr[6]].blk};
					`DTC_O_REP: s_next.rdata = {24'h0, s_reg.ch[i_araddr[6]].rep};
					default: s_next.rresp = `DTC_RESP_ERR;
				endcase
			end
		end
		else if (s_reg.rvalid && i_rready)
			s_next.rvalid = 1'b0;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s_reg <= '0;
			s_reg.st <= DTC_IDLE;
		end
		else
			s_reg <= s_next;
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	chk_burst_len: assert property ($rose(s_reg.st == DTC_RD) |-> // RL1
		s_reg.blen != 4'h0 && s_reg.blen <= (4'h1 << s_reg.ch[s_reg.act].ctrl[`DTC_F_BURST]))
		else $error("burst length out of range");
	chk_block_left: assert property (s_reg.ch[0].busy |-> // RL2
		s_reg.ch[0].blk_left != 17'h0 && s_reg.ch[0].blk_left <= `DTC_BLK_FULL)
		else $error("block count out of range");
	chk_repeat_left: assert property (s_reg.ch[1].busy |-> // RL3
		s_reg.ch[1].rep_left != 9'h0 && s_reg.ch[1].rep_left <= `DTC_REP_FULL)
		else $error("repeat count out of range");
	chk_addr_inc: assert property (rd_iss && !s_reg.act && // RL4
		s_reg.ch[0].ctrl[`DTC_F_SMODE] == `DTC_AM_INC |=>
		s_reg.ch[0].src_cur == $past(s_reg.ch[0].src_cur) + 24'h1)
		else $error("source address did not advance");
	chk_burst_reload: assert property (bend && !s_reg.act && // RL5
		s_reg.ch[0].ctrl[`DTC_F_DRL] == `DTC_RL_BURST |=> s_reg.ch[0].dst_cur == s_reg.ch[0].dst)
		else $error("destination not restored after burst");
	chk_periph_start: assert property (!s_reg.ch[0].busy && s_reg.ch[0].ctrl[`DTC_F_EN] && // RL6
		s_reg.ch[0].ctrl[`DTC_F_TRIG] == `DTC_TRIG_PER && i_periph_req[0] |=> s_reg.ch[0].busy)
		else $error("peripheral trigger ignored");
	chk_done_irq: assert property (done_ev[0] && s_reg.imask[0] |=> o_irq [*1] ##0 // RL8
		s_reg.istat[0]) else $error("completion interrupt missing");
	chk_chain_start: assert property (done_ev[0] && s_reg.ch[0].ctrl[`DTC_F_CHAIN] && // RL9
		s_reg.ch[1].ctrl[`DTC_F_EN] |=> s_reg.ch[1].busy)
		else $error("chained channel not started");
	chk_crc_feed: assert property (wr_acc && s_reg.ch[s_reg.act].ctrl[`DTC_F_CRC] |=> // RL12
		o_crc.valid && o_crc.data == $past(o_wr.data)) else $error("byte not sent to CRC");
	chk_nvm_rate: assert property (rd_iss && is_nvm(s_next.rd.addr) |=> !rd_iss) // RL13
		else $error("nonvolatile read issued back to back");
	chk_fixed_prio: assert property (s_reg.st == DTC_IDLE && cand == 2'b11 && // RL15
		!s_reg.prio |=> s_reg.st == DTC_RD && !s_reg.act) else $error("fixed priority violated");
	chk_alt_prio: assert property (s_reg.st == DTC_IDLE && cand == 2'b11 && // RL15
		s_reg.prio |=> s_reg.act != $past(s_reg.last)) else $error("alternating priority violated");

	cov_txn_done: cover property (done_ev != 2'b00);
	cov_chain: cover property (done_ev[0] ##[1:200] done_ev[1]);
	cov_error: cover property (err_ev != 2'b00);
	cov_rr: cover property (s_reg.prio && cand == 2'b11 && s_reg.st == DTC_IDLE);
endmodule // dtc_top

// ---- inc/dtc_params.svh ----
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
// Register byte offsets on the AXI4-Lite slave
`define DTC_A_PRIO    8'h00
`define DTC_A_ISTAT   8'h04
`define DTC_A_IMASK   8'h08
`define DTC_A_STATUS  8'h0c
// Channel pages: channel 0 at 0x20, channel 1 at 0x40
`define DTC_PG_CH0    3'h1
`define DTC_PG_CH1    3'h2
`define DTC_O_CTRL    5'h00
`define DTC_O_SRC     5'h04
`define DTC_O_DST     5'h08
`define DTC_O_BLK     5'h0c
`define DTC_O_REP     5'h10
// Channel control fields
`define DTC_F_EN      0
`define DTC_F_SWTRIG  1
`define DTC_F_BURST   3:2
`define DTC_F_TRIG    5:4
`define DTC_F_CHAIN   6
`define DTC_F_CRC     7
`define DTC_F_SMODE   9:8
`define DTC_F_DMODE   11:10
`define DTC_F_SRL     13:12
`define DTC_F_DRL     15:14
`define DTC_PRIO_RR   0
// Field codes
`define DTC_TRIG_SW   2'h0
`define DTC_TRIG_PER  2'h1
`define DTC_TRIG_EVT  2'h2
`define DTC_AM_INC    2'h1
`define DTC_AM_DEC    2'h2
`define DTC_RL_BURST  2'h1
`define DTC_RL_BLOCK  2'h2
`define DTC_RL_TXN    2'h3
// Sizes, windows and answers
`define DTC_BLK_FULL  17'h10000
`define DTC_REP_FULL  9'h100
`define DTC_NVM_BASE  24'h001000
`define DTC_NVM_MASK  24'hfff800
`define DTC_RESP_OK   2'h0
`define DTC_RESP_ERR  2'h2
`endif

// ---- inc/dtc_pkg.sv ----
package dtc_pkg;
	typedef enum logic [2:0] {DTC_IDLE = 3'b001, DTC_RD = 3'b010, DTC_WR = 3'b100} dtc_st_t;
	typedef struct packed {
		logic [23:0] src, dst, src_cur, dst_cur;
		logic [15:0] blk;
		logic [16:0] blk_left;
		logic [7:0]  rep;
		logic [8:0]  rep_left;
		logic [15:0] ctrl;
		logic        busy;
	} dtc_chan_t;
	typedef struct packed {logic valid; logic [23:0] addr;} dtc_rd_req_t;
	typedef struct packed {logic ready; logic dvalid; logic [7:0] data; logic err;} dtc_rd_rsp_t;
	typedef struct packed {logic valid; logic [23:0] addr; logic [7:0] data;} dtc_wr_req_t;
	typedef struct packed {logic ready; logic err;} dtc_wr_rsp_t;
	typedef struct packed {logic valid; logic [7:0] data; logic ch;} dtc_crc_t;
	typedef struct packed {
		dtc_chan_t [1:0] ch;
		dtc_st_t         st;
		logic            act, last, prio, nvm_ph;
		logic [3:0]      blen, icnt, rcnt, wcnt;
		logic [7:0][7:0] bbuf;
		logic [3:0]      istat, imask;
		logic            aw_got, w_got, bvalid, rvalid;
		logic [7:0]      awaddr;
		logic [31:0]     wdata, rdata;
		logic [3:0]      wstrb;
		logic [1:0]      bresp, rresp;
		dtc_rd_req_t     rd;
		dtc_wr_req_t     wr;
		dtc_crc_t        crc;
	} dtc_state_t;
endpackage

// ---- tb/dtc_mem_model.sv ----
`timescale 1ns/1ps
module dtc_mem_model (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	// Engine masters
	input  wire dtc_pkg::dtc_rd_req_t i_rd,
	input  wire dtc_pkg::dtc_wr_req_t i_wr,
	output dtc_pkg::dtc_rd_rsp_t      o_rd,
	output dtc_pkg::dtc_wr_rsp_t      o_wr,
	// Bench controls
	input  wire logic                 i_stall,
	input  wire logic                 i_err
);
	import dtc_pkg::*;
	logic [7:0]  mem [8192];
	logic [12:0] pend [$];
	initial
	begin
		for (int k = 0; k < 8192; k++)
			mem[k] = k[7:0] ^ k[12:5];
	end
	// Separate read and write ports, bytes returned in order later
	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pend.delete();
			o_rd <= '0;
			o_wr <= '0;
		end
		else
		begin
			o_rd.dvalid <= 1'b0;
			o_rd.err    <= 1'b0;
			o_rd.data   <= ~o_rd.data;
			if (pend.size() != 0)
			begin
				o_rd.dvalid <= 1'b1;
				o_rd.data   <= mem[pend.pop_front()];
				o_rd.err    <= i_err;
			end
			if (i_rd.valid && o_rd.ready)
				pend.push_back(i_rd.addr[12:0]);
			if (i_wr.valid && o_wr.ready)
				mem[i_wr.addr[12:0]] <= i_wr.data;
			o_rd.ready <= !i_stall;
			o_wr.ready <= !i_stall;
			o_wr.err   <= i_err;
		end
	end
endmodule // dtc_mem_model

// ---- tb/test_two_channel_dma_controller.sv ----
`timescale 1ns/1ps
`include "dtc_params.svh"
module test_two_channel_dma_controller;
	import dtc_pkg::*;
	logic        i_clk = 0;
	logic        i_rst = 1;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, v;
	logic [1:0]  preq = 0, evt = 0, bresp, rresp, r2;
	logic        stall = 0, err = 0, slow = 0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	dtc_rd_req_t rd;
	dtc_rd_rsp_t rd_rsp;
	dtc_wr_req_t wrq;
	dtc_wr_rsp_t wr_rsp;
	dtc_crc_t    crc;
	logic [7:0]  sh [8192];
	int          seed = 24960, fails = 0, tests_run = 0, crc_n = 0, crc_s = 0;
	logic [31:0] r;

	dtc_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_awvalid(awvalid), .o_awready(awready),
		.i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
		.i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
		.i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_periph_req(preq),
		.i_event(evt), .o_rd(rd), .i_rd(rd_rsp), .o_wr(wrq), .i_wr(wr_rsp), .o_crc(crc),
		.o_irq(irq));
	dtc_mem_model mem_m (.i_clk(i_clk), .i_rst(i_rst), .i_rd(rd), .i_wr(wrq), .o_rd(rd_rsp),
		.o_wr(wr_rsp), .i_stall(stall), .i_err(err));

	initial
	begin
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		stall <= slow ? 1'($random(seed)) : 1'b0;
		if (crc.valid === 1'b1)
		begin
			crc_n <= crc_n + 1;
			crc_s <= crc_s + crc.data + 256 * crc.ch;
		end
	end

	function automatic logic [7:0] pat(int k);
		return 8'(k) ^ 8'(k >> 5);
	endfunction
	function automatic int ad(int b, int m, int rl, int i, int bl, int bk);
		int o;
		o = rl == 1 ? i % bk % bl : rl == 2 ? i % bk : i;
		return m == 1 ? b + o : m == 2 ? b - o : b;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic close_out;
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic ta, tw, got;
		logic [1:0] rs;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge i_clk);
			ta = awready;
			tw = wready;
			got = bvalid;
			rs = bresp;
			@(posedge i_clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end while (!got);
		bready <= 1'b0;
		@(posedge i_clk);
		chk(rs, er, "bresp");
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic ta, got;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge i_clk);
			ta = arready;
			got = rvalid;
			d = rdata;
			rs = rresp;
			@(posedge i_clk);
			if (ta)
				arvalid <= 1'b0;
		end while (!got);
		rready <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
		rd_reg(a, v, r2);
		chk(v, e, what);
	endtask
	task automatic chk_irq(input logic e);
		@(negedge i_clk);
		chk(irq, e, "irq");
		@(posedge i_clk);
	endtask
	task automatic wait_ist(input logic [3:0] m);
		int n;
		n = 0;
		do
		begin
			rd_reg(`DTC_A_ISTAT, v, r2);
			n++;
		end while ((v[3:0] & m) != m && n < 400);
	endtask
	task automatic run_one(input int ch, bl, tg, sm, dm, sr, dr, blk, rep, nvm, cr, msk);
		int s, d, pg, c0, s0, e;
		s = nvm ? 'h1180 : 'h0180;
		d = 'h0500;
		pg = ch ? 'h40 : 'h20;
		wr(`DTC_A_IMASK, msk ? 32'hf : 32'h0);
		wr(8'(pg + 4), s);
		wr(8'(pg + 8), d);
		wr(8'(pg + 12), blk);
		wr(8'(pg + 16), rep);
		c0 = crc_n;
		s0 = crc_s;
		e = 0;
		wr(8'(pg), 32'({2'(dr), 2'(sr), 2'(dm), 2'(sm), cr[0], 1'b0, 2'(tg), 2'(bl), tg == 0, 1'b1}));
		if (tg != 0)
		begin
			if (tg == 1)
				preq[ch] <= 1'b1;
			else
				evt[ch] <= 1'b1;
			@(posedge i_clk);
			preq <= 2'b0;
			evt <= 2'b0;
			@(posedge i_clk);
		end
		wait_ist(4'(1 << ch));
		for (int i = 0; i < blk * rep; i++)
		begin
			sh[ad(d, dm, dr, i, 1 << bl, blk)] = pat(ad(s, sm, sr, i, 1 << bl, blk));
			e += pat(ad(s, sm, sr, i, 1 << bl, blk)) + 256 * ch;
		end
		chk(v, 32'h1 << ch, "done status");
		chk_irq(msk[0]);
		chk(crc_n - c0, cr ? blk * rep : 0, "crc bytes");
		chk(crc_s - s0, cr ? e : 0, "crc data and channel");
		for (int a = 'h0480; a < 'h0580; a++)
			chk(mem_m.mem[a], sh[a], "dest byte");
		wr(`DTC_A_ISTAT, 32'hf);
		rd_chk(`DTC_A_ISTAT, 32'h0, "istat clear");
		chk_irq(1'b0);
	endtask

	initial
	begin
		for (int k = 0; k < 8192; k++)
			sh[k] = pat(k);
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd_chk(`DTC_A_STATUS, 32'h4, "status idle");
		rd_chk(`DTC_A_IMASK, 32'h0, "imask reset");
		rd_reg(8'h1c, v, r2);
		chk(v, 32'h0, "unmapped data");
		chk(r2, 2'h2, "unmapped resp");
		wr(8'h1c, 32'h1, 2'h2);
		wr(`DTC_A_PRIO, 32'h1);
		rd_chk(`DTC_A_PRIO, 32'h1, "priority");
		$display("register test done");
		for (int t = 0; t < 24; t++)
		begin
			r = $random(seed);
			slow <= t[1];
			run_one(r[0], t < 4 ? t : r[2:1], t % 3, r[4:3] % 3, r[6:5] % 3, r[8:7], r[10:9],
				t == 0 ? 1 : r[14:11] % 12 + 1, r[16:15] % 3 + 1, r[17], r[18], r[19]);
			$display("transfer test %0d done", t);
		end
		// Read error aborts the channel
		err <= 1'b1;
		wr(8'h40, 32'h3);
		wait_ist(4'h8);
		chk(v, 32'h8, "error status");
		rd_chk(`DTC_A_STATUS, 32'h4, "idle after error");
		err <= 1'b0;
		wr(`DTC_A_ISTAT, 32'hf);
		$display("error test done");
		// Channel 0 hands over to channel 1
		wr(8'h44, 32'h200);
		wr(8'h48, 32'hc00);
		wr(8'h4c, 32'h4);
		wr(8'h50, 32'h1);
		wr(8'h40, 32'h521);
		wr(8'h24, 32'h200);
		wr(8'h28, 32'hc80);
		wr(8'h2c, 32'h4);
		wr(8'h30, 32'h1);
		wr(8'h20, 32'h543);
		wait_ist(4'h3);
		chk(v, 32'h3, "chain done");
		for (int i = 0; i < 4; i++)
		begin
			chk(mem_m.mem['hc00 + i], pat('h200 + i), "chain byte");
			chk(mem_m.mem['hc80 + i], pat('h200 + i), "first channel byte");
		end
		$display("chain test done");
		// Both channels pending, fixed then alternating grant
		for (int p = 0; p < 2; p++)
		begin
			wr(`DTC_A_ISTAT, 32'hf);
			wr(`DTC_A_PRIO, 32'(p));
			for (int k = 0; k < 2; k++)
			begin
				wr(8'('h24 + 'h20 * k), 32'('h300 + 'h40 * k));
				wr(8'('h28 + 'h20 * k), 32'('hd00 + 'h80 * p + 'h40 * k));
				wr(8'('h2c + 'h20 * k), 32'h8);
				wr(8'('h30 + 'h20 * k), 32'h1);
				wr(8'('h20 + 'h20 * k), 32'h521);
			end
			evt <= 2'b11;
			@(posedge i_clk);
			evt <= 2'b00;
			wait_ist(4'h3);
			chk(v, 32'h3, "both done");
			for (int i = 0; i < 8; i++)
			begin
				chk(mem_m.mem['hd00 + 'h80 * p + i], pat('h300 + i), "shared byte ch0");
				chk(mem_m.mem['hd40 + 'h80 * p + i], pat('h340 + i), "shared byte ch1");
			end
			$display("priority test %0d done", p);
		end
		close_out();
	end
	initial
	begin
		#400000;
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		close_out();
	end
endmodule // test_two_channel_dma_controller
